// *** design/vmpr_core.sv ***
// What this block does
// - Profile from acceleration, deceleration, maximum velocity; same linear ramps both directions.
// - Jog, profile position and homing always use the profile.
// - Profile velocity uses the profile only when enable is 1; reset value 1.
// - Profile torque and interpolated position never use the profile.
// - Enable and maximum velocity writes refused while power stage is on.
// - Reference velocity clamped to maximum in jog, profile position, profile velocity and homing only, range 1..2147483647, reset 13200.
// - Enable and halt option act at once; other settings latch at next movement start.
// - Writing zero to acceleration or deceleration is ignored.
// - Acceleration and deceleration range 1..2147483647, reset 600.
// - Deceleration floor 1 in profile velocity, 120 in jog, position, homing.
// - Jerk limitation only in jog, profile position and homing.
// - Jerk 0 is off; 1,2,4..128 ms accepted; reset 0.
// - Jerk writes accepted only while operation finished flag is 1.
// - Halt stops the movement in jog, profile position, profile velocity and homing only; clearing Halt lets it resume.
// - Halt comes from a digital input or a fieldbus command.
// - Halt decelerates by deceleration ramp or torque-limited ramp.
// - Halt option 1 ramp, 3 torque; refused while deceleration is active.
`timescale 1ns/10ps
`default_nettype none
module vmpr_core (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic [2:0]  op_mode_in,
  input  wire logic        power_stage_en_in,
  input  wire logic        op_finished_in,
  input  wire logic [31:0] target_vel_in,
  input  wire logic        halt_fb_in,
  input  wire logic        halt_di_in,
  input  wire logic        halt_di_assigned_in,
  input  wire logic [31:0] halt_torque_step_in,
  input  wire logic [15:0] prm_addr_in,
  input  wire logic        prm_wr_in,
  input  wire logic        prm_rd_in,
  input  wire logic [31:0] prm_wdata_in,
  output logic      [31:0] prm_rdata_out,
  output logic             prm_ack_out,
  output logic             prm_err_out,
  output logic      [31:0] vel_cmd_out,
  output logic             profile_active_out,
  output logic             jerk_active_out,
  output logic             halt_active_out,
  output logic             decel_active_out,
  output logic             ramp_done_out
);
  typedef struct packed {
    logic        [31:0] max_v;
    logic        [31:0] acc;
    logic        [31:0] dec;
    logic        [15:0] jerk;
    logic               en;
    logic        [15:0] hopt;
    logic        [31:0] max_a;
    logic        [31:0] acc_a;
    logic        [31:0] dec_a;
    logic        [15:0] jerk_a;
    logic signed [31:0] vel;
    logic signed [31:0] out;
    logic               dec_act;
    logic               ack;
    logic               err;
    logic        [31:0] rdata;
  } vmpr_core_state_t;

  vmpr_core_state_t s_q;
  vmpr_core_state_t s_d;

  vmpr_step_if step_if ();

  vmpr_tick u_tick (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .step_if    (step_if)
  );

  vmpr_slew u_slew (
    .step_if (step_if)
  );

  function automatic logic vmpr_is_pos_mode(input logic [2:0] m);
    return (m == vmpr_pkg::VMPR_MODE_JOG) || (m == vmpr_pkg::VMPR_MODE_PPOS) ||
           (m == vmpr_pkg::VMPR_MODE_HOMING);
  endfunction

  function automatic logic vmpr_jerk_ok(input logic [31:0] w);
    logic [15:0] j;
    j = w[15:0];
    return (w[31:16] == 16'h0000) && (j <= vmpr_pkg::JERK_MAX_MS) && ((j & (j - 16'h0001)) == 16'h0000);
  endfunction

  function automatic logic [3:0] vmpr_jerk_shift(input logic [15:0] j);
    logic [3:0] sh;
    sh = 4'h1;
    for (int i = 1; i < 8; i++) begin
      if (j[i]) begin
        sh = 4'(i + 1);
      end
    end
    return sh;
  endfunction

  logic               pos_mode;
  logic               pv_mode;
  logic               halt_req;
  logic               profile_on;
  logic               ramp_run;
  logic               jerk_on;
  logic signed [31:0] max_s;
  logic signed [31:0] tgt_s;
  logic signed [31:0] clamped;
  logic        [31:0] dec_eff;
  logic signed [32:0] jdiff;
  logic signed [32:0] jadj;

  always_comb begin
    pos_mode = vmpr_is_pos_mode(op_mode_in);
    pv_mode  = (op_mode_in == vmpr_pkg::VMPR_MODE_PVEL);
    // Input Halt counts only once the input has been given the Halt function.
    halt_req = halt_fb_in | (halt_di_in & halt_di_assigned_in);
    profile_on = pos_mode | (pv_mode & s_q.en);
    ramp_run   = profile_on | (halt_req & (pos_mode | pv_mode));
    jerk_on    = pos_mode && (s_q.jerk_a != 16'h0000);
    max_s   = $signed(s_q.max_a);
    tgt_s   = $signed(target_vel_in);
    clamped = tgt_s;
    if (tgt_s > max_s) begin
      clamped = max_s;
    end else if (tgt_s < -max_s) begin
      clamped = -max_s;
    end
    dec_eff = s_q.dec_a;
    if (pos_mode && s_q.dec_a < vmpr_pkg::DEC_MIN_POS) begin
      dec_eff = vmpr_pkg::DEC_MIN_POS;
    end
  end

  always_comb begin
    step_if.cur     = s_q.vel;
    step_if.tgt     = halt_req ? 32'sh0 : clamped;
    step_if.up_step = s_q.acc_a;
    // The torque ramp step comes from the current limiter; zero falls back to the ramp.
    if (halt_req && s_q.hopt == vmpr_pkg::HALT_OPT_TORQ && halt_torque_step_in != 32'h0) begin
      step_if.down_step = halt_torque_step_in;
    end else begin
      step_if.down_step = dec_eff;
    end
  end

  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    jdiff   = '0;
    jadj    = '0;
    if (!ramp_run) begin
      if (pv_mode) begin
        s_d.vel = clamped;
      end else begin
        s_d.vel = tgt_s;
      end
      s_d.dec_act = 1'b0;
    end else if (step_if.tick) begin
      s_d.vel     = step_if.nxt;
      s_d.dec_act = step_if.slowing;
    end
    if (jerk_on && ramp_run) begin
      if (step_if.tick) begin
        // First-order smoothing stands in for a full jerk filter to save area.
        jdiff = {s_d.vel[31], s_d.vel} - {s_q.out[31], s_q.out};
        jadj  = jdiff >>> vmpr_jerk_shift(s_q.jerk_a);
        s_d.out = (jadj == 33'sh0) ? s_d.vel : s_q.out + jadj[31:0];
      end
    end else begin
      s_d.out = s_d.vel;
    end
    if (s_q.vel == 32'sh0 && s_q.out == 32'sh0) begin
      s_d.max_a  = s_q.max_v;
      s_d.acc_a  = s_q.acc;
      s_d.dec_a  = s_q.dec;
      s_d.jerk_a = s_q.jerk;
    end
    if (prm_wr_in) begin
      s_d.ack = 1'b1;
      unique case (prm_addr_in)
        vmpr_pkg::ADDR_MAX_VEL: begin
          if (power_stage_en_in || prm_wdata_in == 32'h0 || prm_wdata_in[31]) begin
            s_d.err = 1'b1;
          end else begin
            s_d.max_v = prm_wdata_in;
          end
        end
        vmpr_pkg::ADDR_ACC: begin
          if (prm_wdata_in[31]) begin
            s_d.err = 1'b1;
          end else if (prm_wdata_in != 32'h0) begin
            s_d.acc = prm_wdata_in;
          end
        end
        vmpr_pkg::ADDR_DEC: begin
          if (prm_wdata_in[31]) begin
            s_d.err = 1'b1;
          end else if (prm_wdata_in != 32'h0) begin
            s_d.dec = prm_wdata_in;
          end
        end
        vmpr_pkg::ADDR_JERK: begin
          if (!op_finished_in || !vmpr_jerk_ok(prm_wdata_in)) begin
            s_d.err = 1'b1;
          end else begin
            s_d.jerk = prm_wdata_in[15:0];
          end
        end
        vmpr_pkg::ADDR_ENABLE: begin
          if (power_stage_en_in || prm_wdata_in[31:1] != 31'h0) begin
            s_d.err = 1'b1;
          end else begin
            s_d.en = prm_wdata_in[0];
          end
        end
        vmpr_pkg::ADDR_HALT_OPT: begin
          if (s_q.dec_act || (prm_wdata_in != 32'(vmpr_pkg::HALT_OPT_DEC) &&
                              prm_wdata_in != 32'(vmpr_pkg::HALT_OPT_TORQ))) begin
            s_d.err = 1'b1;
          end else begin
            s_d.hopt = prm_wdata_in[15:0];
          end
        end
        default: begin
          s_d.err = 1'b1;
        end
      endcase
    end else if (prm_rd_in) begin
      s_d.ack = 1'b1;
      unique case (prm_addr_in)
        vmpr_pkg::ADDR_MAX_VEL:  s_d.rdata = s_q.max_v;
        vmpr_pkg::ADDR_ACC:      s_d.rdata = s_q.acc;
        vmpr_pkg::ADDR_DEC:      s_d.rdata = s_q.dec;
        vmpr_pkg::ADDR_JERK:     s_d.rdata = {16'h0000, s_q.jerk};
        vmpr_pkg::ADDR_ENABLE:   s_d.rdata = {31'h0, s_q.en};
        vmpr_pkg::ADDR_HALT_OPT: s_d.rdata = {16'h0000, s_q.hopt};
        vmpr_pkg::ADDR_VEL_CMD:  s_d.rdata = s_q.out;
        default: begin
          s_d.rdata = 32'h0;
          s_d.err   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q        <= '0;
      s_q.max_v  <= vmpr_pkg::RST_MAX_VEL;
      s_q.acc    <= vmpr_pkg::RST_ACC;
      s_q.dec    <= vmpr_pkg::RST_DEC;
      s_q.jerk   <= vmpr_pkg::RST_JERK;
      s_q.en     <= vmpr_pkg::RST_ENABLE;
      s_q.hopt   <= vmpr_pkg::RST_HALT_OPT;
      s_q.max_a  <= vmpr_pkg::RST_MAX_VEL;
      s_q.acc_a  <= vmpr_pkg::RST_ACC;
      s_q.dec_a  <= vmpr_pkg::RST_DEC;
      s_q.jerk_a <= vmpr_pkg::RST_JERK;
    end else begin
      s_q <= s_d;
    end
  end

  assign prm_rdata_out      = s_q.rdata;
  assign prm_ack_out        = s_q.ack;
  assign prm_err_out        = s_q.err;
  assign vel_cmd_out        = s_q.out;
  assign profile_active_out = profile_on;
  assign jerk_active_out    = jerk_on;
  assign halt_active_out    = halt_req;
  assign decel_active_out   = s_q.dec_act;
  assign ramp_done_out      = (s_q.vel == step_if.tgt);

  chk_mode_always_on: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    vmpr_is_pos_mode(op_mode_in) |-> profile_active_out)
    else $error("profile not active in a positioning mode");

  chk_pv_follows_en: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (op_mode_in == vmpr_pkg::VMPR_MODE_PVEL) |-> (profile_active_out == s_q.en))
    else $error("profile velocity mode ignores enable");

  chk_torque_no_prof: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (op_mode_in == vmpr_pkg::VMPR_MODE_PTORQ || op_mode_in == vmpr_pkg::VMPR_MODE_IPOS) |-> !profile_active_out)
    else $error("profile active in torque or interpolated mode");

  chk_enable_locked: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (prm_wr_in && power_stage_en_in && prm_addr_in == vmpr_pkg::ADDR_ENABLE) |=> ($stable(s_q.en) && prm_err_out))
    else $error("enable changed with power stage on");

  chk_vel_clamped: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (pv_mode || pos_mode) && ramp_run |-> (s_q.vel <= $signed(s_q.max_a) && s_q.vel >= -$signed(s_q.max_a)))
    else $error("profiled velocity above maximum");

  chk_acc_zero_kept: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (prm_wr_in && prm_addr_in == vmpr_pkg::ADDR_ACC && prm_wdata_in == 32'h0) |=> $stable(s_q.acc) ##1 $stable(s_q.acc))
    else $error("zero write altered acceleration");

  chk_jerk_locked: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (prm_wr_in && !op_finished_in && prm_addr_in == vmpr_pkg::ADDR_JERK) |=> ($stable(s_q.jerk) && prm_err_out))
    else $error("jerk changed while mode active");

  chk_jerk_mode_only: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    jerk_active_out |-> vmpr_is_pos_mode(op_mode_in))
    else $error("jerk limitation outside positioning modes");

  chk_halt_slows: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (halt_req && ramp_run && s_q.vel != 32'sh0) |=>
      (($past(s_q.vel) > 32'sh0) ? (s_q.vel <= $past(s_q.vel)) : (s_q.vel >= $past(s_q.vel))))
    else $error("velocity grows during halt");

  chk_step_once: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ramp_run && !step_if.tick) |=> (!$past(ramp_run) || $stable(s_q.vel)))
    else $error("velocity changed between control cycles");

  chk_halt_opt_code: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (prm_wr_in && prm_addr_in == vmpr_pkg::ADDR_HALT_OPT && (s_q.dec_act || prm_wdata_in == 32'h2))
    |=> ($stable(s_q.hopt) && prm_err_out))
    else $error("halt option accepted when it must be refused");
endmodule
`default_nettype wire

// *** design/vmpr_pkg.sv ***
`default_nettype none
package vmpr_pkg;
  // Parameter addresses as seen on the fieldbus.
  localparam logic [15:0] ADDR_MAX_VEL   = 16'h0612;
  localparam logic [15:0] ADDR_ACC       = 16'h0614;
  localparam logic [15:0] ADDR_DEC       = 16'h0616;
  localparam logic [15:0] ADDR_JERK      = 16'h061a;
  localparam logic [15:0] ADDR_ENABLE    = 16'h0656;
  localparam logic [15:0] ADDR_HALT_OPT  = 16'h062e;
  localparam logic [15:0] ADDR_VEL_CMD   = 16'h0700;

  localparam logic [31:0] RST_MAX_VEL    = 32'h00003390;
  localparam logic [31:0] RST_ACC        = 32'h00000258;
  localparam logic [31:0] RST_DEC        = 32'h00000258;
  localparam logic [15:0] RST_JERK       = 16'h0000;
  localparam logic        RST_ENABLE     = 1'b1;
  localparam logic [15:0] RST_HALT_OPT   = 16'h0001;

  localparam logic [15:0] HALT_OPT_DEC   = 16'h0001;
  localparam logic [15:0] HALT_OPT_TORQ  = 16'h0003;
  localparam logic [31:0] DEC_MIN_POS    = 32'h00000078;
  localparam logic [15:0] JERK_MAX_MS    = 16'h0080;

  // Control cycle of the drive; the ramp advances once per cycle.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CTRL_CYCLE_NS  = 1000;
  localparam int CTRL_CYCLES    = (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W         = 16;

  typedef enum logic [2:0] {
    VMPR_MODE_NONE   = 3'h0,
    VMPR_MODE_JOG    = 3'h1,
    VMPR_MODE_PPOS   = 3'h2,
    VMPR_MODE_PVEL   = 3'h3,
    VMPR_MODE_HOMING = 3'h4,
    VMPR_MODE_PTORQ  = 3'h5,
    VMPR_MODE_IPOS   = 3'h6
  } vmpr_mode_t;
endpackage
`default_nettype wire

// *** design/vmpr_step_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface vmpr_step_if;
  logic               tick;
  logic signed [31:0] cur;
  logic signed [31:0] tgt;
  logic        [31:0] up_step;
  logic        [31:0] down_step;
  logic signed [31:0] nxt;
  logic               slowing;

  modport tick_src (output tick);
  modport slew     (input cur, input tgt, input up_step, input down_step, output nxt, output slowing);
  modport core     (input tick, input nxt, input slowing, output cur, output tgt, output up_step, output down_step);
endinterface
`default_nettype wire

// *** design/vmpr_tick.sv ***
`timescale 1ns/10ps
`default_nettype none
module vmpr_tick (
  input  wire logic          clk_sys_in,
  input  wire logic          rstn_in,
  vmpr_step_if.tick_src      step_if
);
  typedef struct packed {
    logic [vmpr_pkg::TICK_W-1:0] cnt;
    logic                        tick;
  } vmpr_tick_state_t;

  vmpr_tick_state_t s_q;
  vmpr_tick_state_t s_d;

  localparam logic [vmpr_pkg::TICK_W-1:0] LAST = vmpr_pkg::TICK_W'(vmpr_pkg::CTRL_CYCLES - 1);

  always_comb begin
    s_d = s_q;
    s_d.tick = (s_q.cnt == LAST);
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign step_if.tick = s_q.tick;
endmodule
`default_nettype wire

// *** design/vmpr_slew.sv ***
`timescale 1ns/10ps
`default_nettype none
module vmpr_slew (
  vmpr_step_if.slew step_if
);
  // Wide arithmetic so that a full-scale step never wraps around.
  logic signed [33:0] c;
  logic signed [33:0] t;
  logic signed [33:0] n;
  logic signed [33:0] up;
  logic signed [33:0] dn;

  always_comb begin
    c  = {{2{step_if.cur[31]}}, step_if.cur};
    t  = {{2{step_if.tgt[31]}}, step_if.tgt};
    up = $signed({2'b00, step_if.up_step});
    dn = $signed({2'b00, step_if.down_step});
    n  = c;
    step_if.slowing = 1'b0;
    if (t > c) begin
      step_if.slowing = (c < 0);
      n = (c < 0) ? c + dn : c + up;
      if (n > t) begin
        n = t;
      end
      // A reversal stops at zero first so the deceleration ramp is honoured.
      if (c < 0 && n > 0) begin
        n = '0;
      end
    end else if (t < c) begin
      step_if.slowing = (c > 0);
      n = (c > 0) ? c - dn : c - up;
      if (n < t) begin
        n = t;
      end
      if (c > 0 && n < 0) begin
        n = '0;
      end
    end
    step_if.nxt = n[31:0];
  end
endmodule
`default_nettype wire

// *** testbench/vmpr_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module vmpr_master (
  input  wire logic        clk_in,
  output logic      [2:0]  op_mode_out,
  output logic             power_out,
  output logic             op_fin_out,
  output logic      [31:0] target_out,
  output logic             halt_fb_out,
  output logic             halt_di_out,
  output logic             di_assigned_out
);
  initial begin
    op_mode_out = 3'h1;
    power_out = 1'b1;
    op_fin_out = 1'b1;
    target_out = 32'h0;
    halt_fb_out = 1'b0;
    halt_di_out = 1'b0;
    di_assigned_out = 1'b0;
  end

  task automatic move(input logic [2:0] m, input logic [31:0] t);
    @(posedge clk_in);
    #1;
    op_mode_out = m;
    target_out = t;
  endtask

  task automatic status(input logic p, input logic f);
    @(posedge clk_in);
    #1;
    power_out = p;
    op_fin_out = f;
  endtask

  // Only one Halt path is ever commanded at a time.
  task automatic halt_bus(input logic h);
    @(posedge clk_in);
    #1;
    halt_di_out = 1'b0;
    halt_fb_out = h;
  endtask

  // The input gets its Halt function one cycle before it is used.
  task automatic halt_input(input logic h);
    @(posedge clk_in);
    #1;
    di_assigned_out = 1'b1;
    halt_fb_out = 1'b0;
    @(posedge clk_in);
    #1;
    halt_di_out = h;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_velocity_motion_profile_ramp.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_velocity_motion_profile_ramp;
  logic        clk_sys_in;
  logic        rstn_in;
  logic [2:0]  op_mode_in;
  logic        power_stage_en_in;
  logic        op_finished_in;
  logic [31:0] target_vel_in;
  logic        halt_fb_in;
  logic        halt_di_in;
  logic        halt_di_assigned_in;
  logic [31:0] halt_torque_step_in;
  logic [15:0] prm_addr_in;
  logic        prm_wr_in;
  logic        prm_rd_in;
  logic [31:0] prm_wdata_in;
  logic [31:0] prm_rdata_out;
  logic        prm_ack_out;
  logic        prm_err_out;
  logic [31:0] vel_cmd_out;
  logic        profile_active_out;
  logic        jerk_active_out;
  logic        halt_active_out;
  logic        decel_active_out;
  logic        ramp_done_out;
  logic        pa;
  int          fail_count;
  int          n_compared;
  int          m;
  int          en;

  vmpr_master vmpr_master_i (
    .clk_in          (clk_sys_in),
    .op_mode_out     (op_mode_in),
    .power_out       (power_stage_en_in),
    .op_fin_out      (op_finished_in),
    .target_out      (target_vel_in),
    .halt_fb_out     (halt_fb_in),
    .halt_di_out     (halt_di_in),
    .di_assigned_out (halt_di_assigned_in)
  );

  vmpr_core vmpr_core_i (
    .clk_sys_in, .rstn_in, .op_mode_in, .power_stage_en_in, .op_finished_in,
    .target_vel_in, .halt_fb_in, .halt_di_in, .halt_di_assigned_in,
    .halt_torque_step_in, .prm_addr_in, .prm_wr_in, .prm_rd_in, .prm_wdata_in,
    .prm_rdata_out, .prm_ack_out, .prm_err_out, .vel_cmd_out, .profile_active_out,
    .jerk_active_out, .halt_active_out, .decel_active_out, .ramp_done_out
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic complete_run;
    $display("mismatches %0d of %0d compared", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_val({31'h0, got}, {31'h0, exp});
  endtask

  // One parameter request; for a read d is the expected data.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e);
    int i;
    @(posedge clk_sys_in);
    #1;
    prm_wr_in = w;
    prm_rd_in = ~w;
    prm_addr_in = a;
    prm_wdata_in = d;
    @(posedge clk_sys_in);
    #1;
    prm_wr_in = 1'b0;
    prm_rd_in = 1'b0;
    for (i = 0; i < 4 && prm_ack_out !== 1'b1; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
    if (prm_ack_out !== 1'b1) begin
      fail_count++;
      complete_run();
    end
    check_bit(prm_err_out, e);
    if (!w && !e) begin
      check_val(prm_rdata_out, d);
    end
  endtask

  // Waits for the next change of the velocity command, which moves once per tick.
  task automatic step(input logic [31:0] exp);
    logic [31:0] prev;
    int          i;
    prev = vel_cmd_out;
    for (i = 0; i < 300 && vel_cmd_out === prev; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
    if (vel_cmd_out === prev) begin
      fail_count++;
      complete_run();
    end
    check_val(vel_cmd_out, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask

  initial begin
    fail_count = 0;
    n_compared = 0;
    rstn_in = 1'b0;
    halt_torque_step_in = 32'h0;
    prm_addr_in = 16'h0;
    prm_wr_in = 1'b0;
    prm_rd_in = 1'b0;
    prm_wdata_in = 32'h0;
    repeat (12) @(posedge clk_sys_in);
    #1;
    rstn_in = 1'b1;
    xfer(0, vmpr_pkg::ADDR_MAX_VEL, 32'h3390, 0);
    xfer(0, vmpr_pkg::ADDR_ACC, 32'h258, 0);
    xfer(0, vmpr_pkg::ADDR_DEC, 32'h258, 0);
    xfer(0, vmpr_pkg::ADDR_JERK, 32'h0, 0);
    xfer(0, vmpr_pkg::ADDR_ENABLE, 32'h1, 0);
    xfer(0, vmpr_pkg::ADDR_HALT_OPT, 32'h1, 0);
    xfer(1, vmpr_pkg::ADDR_MAX_VEL, 32'h1388, 1);
    xfer(1, vmpr_pkg::ADDR_ENABLE, 32'h0, 1);
    vmpr_master_i.status(0, 0);
    xfer(1, vmpr_pkg::ADDR_MAX_VEL, 32'h0, 1);
    xfer(1, vmpr_pkg::ADDR_MAX_VEL, 32'h1388, 0);
    xfer(0, vmpr_pkg::ADDR_MAX_VEL, 32'h1388, 0);
    xfer(1, vmpr_pkg::ADDR_ACC, 32'h0, 0);
    xfer(1, vmpr_pkg::ADDR_DEC, 32'h0, 0);
    xfer(0, vmpr_pkg::ADDR_ACC, 32'h258, 0);
    xfer(0, vmpr_pkg::ADDR_DEC, 32'h258, 0);
    xfer(1, vmpr_pkg::ADDR_ACC, 32'h80000000, 1);
    xfer(1, vmpr_pkg::ADDR_JERK, 32'h8, 1);
    vmpr_master_i.status(1, 1);
    xfer(1, vmpr_pkg::ADDR_JERK, 32'h3, 1);
    xfer(1, vmpr_pkg::ADDR_HALT_OPT, 32'h2, 1);
    xfer(0, 16'h0000, 32'h0, 1);
    xfer(1, vmpr_pkg::ADDR_VEL_CMD, 32'h0, 1);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_JOG, 32'h3e8);
    step(32'h258);
    step(32'h3e8);
    check_bit(ramp_done_out, 1);
    check_bit(decel_active_out, 0);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_JOG, 32'hfffffc18);
    step(32'h190);
    step(32'h0);
    step(32'hfffffda8);
    step(32'hfffffc18);
    vmpr_master_i.halt_bus(1);
    // The Halt flag is combinational, so let the new input settle before looking.
    #1;
    check_bit(halt_active_out, 1);
    step(32'hfffffe70);
    check_bit(decel_active_out, 1);
    xfer(1, vmpr_pkg::ADDR_HALT_OPT, 32'h3, 1);
    step(32'h0);
    vmpr_master_i.halt_bus(0);
    step(32'hfffffda8);
    step(32'hfffffc18);
    xfer(1, vmpr_pkg::ADDR_HALT_OPT, 32'h3, 0);
    halt_torque_step_in = 32'hfa;
    vmpr_master_i.halt_input(1);
    #1;
    check_bit(halt_active_out, 1);
    step(32'hfffffd12);
    vmpr_master_i.halt_input(0);
    step(32'hfffffc18);
    xfer(1, vmpr_pkg::ADDR_ACC, 32'h64, 0);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_JOG, 32'hfffff830);
    step(32'hfffff9c0);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_JOG, 32'h0);
    step(32'hfffffc18);
    step(32'hfffffe70);
    step(32'h0);
    xfer(1, vmpr_pkg::ADDR_ACC, 32'h258, 0);
    xfer(1, vmpr_pkg::ADDR_DEC, 32'h32, 0);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_JOG, 32'h12c);
    step(32'h12c);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_JOG, 32'h0);
    step(32'hb4);
    step(32'h3c);
    step(32'h0);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_PVEL, 32'h64);
    step(32'h64);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_PVEL, 32'h0);
    step(32'h32);
    step(32'h0);
    vmpr_master_i.status(0, 1);
    xfer(1, vmpr_pkg::ADDR_JERK, 32'h8, 0);
    // With 8 ms smoothing the first tick moves the output by a sixteenth of the step.
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_JOG, 32'h258);
    step(32'h25);
    // The enable write takes effect at once, so the flag is checked right after it.
    for (m = 0; m < 7; m++) begin
      for (en = 0; en < 2; en++) begin
        vmpr_master_i.move(m[2:0], 32'h0);
        xfer(1, vmpr_pkg::ADDR_ENABLE, en, 0);
        pa = (m == 1 || m == 2 || m == 4);
        check_bit(jerk_active_out, pa);
        check_bit(profile_active_out, pa || (m == 3 && en == 1));
      end
    end
    xfer(1, vmpr_pkg::ADDR_ENABLE, 32'h0, 0);
    xfer(1, vmpr_pkg::ADDR_JERK, 32'h0, 0);
    vmpr_master_i.status(1, 1);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_PVEL, 32'h2328);
    settle();
    check_val(vel_cmd_out, 32'h1388);
    vmpr_master_i.move(vmpr_pkg::VMPR_MODE_PTORQ, 32'h2328);
    settle();
    check_val(vel_cmd_out, 32'h2328);
    xfer(0, vmpr_pkg::ADDR_VEL_CMD, 32'h2328, 0);
    complete_run();
  end
endmodule
`default_nettype wire
